// File: hw/afc_pkg.sv
// package for the converter function configuration register bank
// assumes a byte-wide register port and 14-bit offset-binary samples
// Operation
// - a commit write copies every shadow setting into the active set at once
// - host writes one to the transfer location; the commit bit then clears itself
// - per-channel power field: 00/11 normal, 01 full shutdown, 10 standby
// - global bit picks shutdown pin action: clear gives shutdown, set gives standby
// - clock register bit 0 enables the duty cycle stabilizer, set after reset
// - three-bit divide field divides the input clock by value plus one
// - any divide value other than 000 forces the stabilizer on
// - three-bit per-channel test field picks normal data (000) or one of seven output patterns
// - a selected test pattern replaces the converted data on that channel
// - two per-channel bits reset the long and short pseudorandom generators
// - global bit selects CMOS outputs when clear, LVDS outputs when set
// - global bit interleaves both channels on one CMOS bus
// - per-channel active-low enable bit, when set, turns the data drivers off
// - per-channel invert bit inverts the output data word
// - format field: 00/11 offset binary, 01 two's complement, 10 Gray code
// - global drive bit picks normal drive when clear, reduced drive when set
// - local writes go to every selected channel; reads with both selected give A
package afc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 14;
    // register addresses
    localparam logic [8:0] ADDR_CHAN_INDEX = 9'h005;
    localparam logic [8:0] ADDR_POWER = 9'h008;
    localparam logic [8:0] ADDR_CLOCK = 9'h009;
    localparam logic [8:0] ADDR_DIVIDE = 9'h00b;
    localparam logic [8:0] ADDR_TEST = 9'h00d;
    localparam logic [8:0] ADDR_OFFSET = 9'h010;
    localparam logic [8:0] ADDR_OUTPUT = 9'h014;
    localparam logic [8:0] ADDR_COMMIT = 9'h0ff;
    // field positions
    localparam int POWER_PIN_BIT = 5;
    localparam int TEST_RST_LONG_BIT = 5;
    localparam int TEST_RST_SHORT_BIT = 4;
    localparam int OUT_DRIVE_BIT = 7;
    localparam int OUT_LVDS_BIT = 6;
    localparam int OUT_ILV_BIT = 5;
    localparam int OUT_OEN_BIT = 4;
    localparam int OUT_INV_BIT = 2;
    localparam int COMMIT_BIT = 0;
    // reset values
    localparam logic [1:0] CHAN_INDEX_RESET = 2'h3;
    localparam logic DCS_RESET = 1'b1;
    localparam logic [22:0] LONG_SEED = 23'h7fffff;
    localparam logic [8:0] SHORT_SEED = 9'h1ff;
    // power modes
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_OFF = 2'h1;
    localparam logic [1:0] PWR_STANDBY = 2'h2;
    // output formats
    localparam logic [1:0] FMT_TWOS = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    // test pattern selections and fixed words
    localparam logic [2:0] TST_OFF = 3'h0;
    localparam logic [2:0] TST_MID = 3'h1;
    localparam logic [2:0] TST_POS = 3'h2;
    localparam logic [2:0] TST_NEG = 3'h3;
    localparam logic [2:0] TST_CHECK = 3'h4;
    localparam logic [2:0] TST_LONG = 3'h5;
    localparam logic [2:0] TST_SHORT = 3'h6;
    localparam logic [2:0] TST_TOGGLE = 3'h7;
    localparam logic [13:0] MIDSCALE_CODE = 14'h2000;
    localparam logic [13:0] FULL_SCALE_CODE = 14'h3fff;
    localparam logic [13:0] ZERO_CODE = 14'h0000;
    localparam logic [13:0] CHECK_CODE = 14'h2aaa;
    // saturation limits for offset-corrected samples
    localparam logic signed [15:0] SAMPLE_MAX = 16'sh3fff;
    localparam logic signed [15:0] SAMPLE_MIN = 16'sh0000;

    // global settings
    typedef struct packed {
        logic pin_stby;
        logic dcs;
        logic [2:0] div;
        logic drive;
        logic lvds;
        logic ilv;
    } afc_glob_type;

    // per-channel settings
    typedef struct packed {
        logic [1:0] pwr;
        logic [2:0] tst;
        logic rst_long;
        logic rst_short;
        logic [5:0] ofs;
        logic oe_n;
        logic inv;
        logic [1:0] fmt;
    } afc_chan_type;

    // whole state of the register bank and output path
    typedef struct packed {
        afc_glob_type g_sh;
        afc_glob_type g_act;
        afc_chan_type [1:0] c_sh;
        afc_chan_type [1:0] c_act;
        logic [1:0] chsel;
        logic commit;
        logic [7:0] rdata;
        logic pin_s1;
        logic pin_s2;
        logic [1:0][22:0] lfsr_l;
        logic [1:0][8:0] lfsr_s;
        logic [1:0] alt;
        logic ilv_sel;
        logic [1:0][13:0] dout;
        logic [1:0] doe;
        logic dvalid;
        logic dchan;
        logic [1:0] pd;
        logic [1:0] sb;
        logic dcs_on;
        logic lvds;
        logic drive;
    } afc_state_type;

    // divider state
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } afc_div_state_type;
endpackage

// File: hw/afc_clkdiv.sv
// sample clock divider: one tick every ratio code plus one input clocks
// assumes the ratio code comes from the active register set on clk
`timescale 1ns/1ps
module afc_clkdiv #(
    parameter int CODE_W = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [CODE_W-1:0] ratio_code,
    output logic tick
);
    afc_pkg::afc_div_state_type s_q, s_d;

    // count 0..code, tick at the wrap
    always_comb begin
        s_d = s_q;
        if (s_q.cnt >= ratio_code) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 3'h1;
            s_d.tick = 1'b0;
        end
    end

    // register state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    // tick spacing of two when the ratio code is one
    div_one_a: assert property (@(posedge clk) disable iff (!nrst)
        (s_q.tick && ratio_code == 3'h1 && $stable(ratio_code)) |=> !s_q.tick ##1 s_q.tick)
        else $error("divide by two tick spacing wrong");
endmodule

// File: hw/afc_regs.sv
// converter function configuration bank with test pattern and output formatting
// assumes the serial shifter presents byte writes and reads on clk
`timescale 1ns/1ps
module afc_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic pdwn_pin,
    input wire logic [1:0][13:0] adc_data,
    output logic [1:0][13:0] data_out,
    output logic [1:0] data_oe,
    output logic data_valid,
    output logic data_chan,
    output logic [1:0] chan_pd,
    output logic [1:0] chan_sb,
    output logic dcs_on,
    output logic bus_lvds,
    output logic drive_low
);
    afc_pkg::afc_state_type s_q, s_d;
    logic tick;

    // sample clock from the active divide setting
    afc_clkdiv #(.CODE_W(3)) u_div (
        .clk(clk),
        .nrst(nrst),
        .ratio_code(s_q.g_act.div),
        .tick(tick)
    );

    // offset correction with saturation
    function automatic logic [13:0] apply_offset(input logic [13:0] w, input logic [5:0] o);
        logic signed [15:0] sum;
        sum = signed'({2'b00, w}) + signed'({{10{o[5]}}, o});
        if (sum > afc_pkg::SAMPLE_MAX) begin
            return afc_pkg::FULL_SCALE_CODE;
        end else if (sum < afc_pkg::SAMPLE_MIN) begin
            return afc_pkg::ZERO_CODE;
        end
        return sum[13:0];
    endfunction

    // number format then inversion
    function automatic logic [13:0] format_word(input logic [13:0] w, input logic [1:0] f,
            input logic inv);
        logic [13:0] r;
        r = w;
        if (f == afc_pkg::FMT_TWOS) begin
            r = {~w[13], w[12:0]};
        end else if (f == afc_pkg::FMT_GRAY) begin
            r = w ^ {1'b0, w[13:1]};
        end
        if (inv) begin
            r = ~r;
        end
        return r;
    endfunction

    // pattern or corrected sample per channel
    function automatic logic [13:0] pick_word(input afc_pkg::afc_chan_type c,
            input logic [13:0] adc, input logic alt, input logic [22:0] ll,
            input logic [8:0] ls);
        logic [13:0] w;
        w = apply_offset(adc, c.ofs);
        unique case (c.tst)
            afc_pkg::TST_OFF: w = apply_offset(adc, c.ofs);
            afc_pkg::TST_MID: w = afc_pkg::MIDSCALE_CODE;
            afc_pkg::TST_POS: w = afc_pkg::FULL_SCALE_CODE;
            afc_pkg::TST_NEG: w = afc_pkg::ZERO_CODE;
            afc_pkg::TST_CHECK: w = alt ? afc_pkg::CHECK_CODE : ~afc_pkg::CHECK_CODE;
            afc_pkg::TST_LONG: w = ll[13:0];
            afc_pkg::TST_SHORT: w = {ls, ls[8:4]};
            afc_pkg::TST_TOGGLE: w = alt ? afc_pkg::FULL_SCALE_CODE : afc_pkg::ZERO_CODE;
        endcase
        return w;
    endfunction

    // next state
    always_comb begin
        logic ch;
        logic pin;
        logic normal;
        logic [1:0][13:0] word;
        afc_pkg::afc_chan_type rc;
        ch = 1'b0;
        pin = s_q.pin_s2;
        normal = 1'b0;
        word = '0;
        rc = '0;
        s_d = s_q;
        // shutdown pin synchroniser
        s_d.pin_s1 = pdwn_pin;
        s_d.pin_s2 = s_q.pin_s1;
        // commit bit clears itself on the same edge as the copy
        s_d.commit = 1'b0;
        if (s_q.commit) begin
            s_d.g_act = s_q.g_sh;
            s_d.c_act = s_q.c_sh;
        end

        // register writes, unused bits dropped
        if (reg_wr) begin
            unique case (reg_addr)
                afc_pkg::ADDR_CHAN_INDEX: s_d.chsel = reg_wdata[1:0];
                afc_pkg::ADDR_CLOCK: s_d.g_sh.dcs = reg_wdata[0];
                afc_pkg::ADDR_DIVIDE: s_d.g_sh.div = reg_wdata[2:0];
                afc_pkg::ADDR_COMMIT: s_d.commit = reg_wdata[afc_pkg::COMMIT_BIT];
                afc_pkg::ADDR_POWER: s_d.g_sh.pin_stby = reg_wdata[afc_pkg::POWER_PIN_BIT];
                afc_pkg::ADDR_OUTPUT: begin
                    s_d.g_sh.drive = reg_wdata[afc_pkg::OUT_DRIVE_BIT];
                    s_d.g_sh.lvds = reg_wdata[afc_pkg::OUT_LVDS_BIT];
                    s_d.g_sh.ilv = reg_wdata[afc_pkg::OUT_ILV_BIT];
                end
                default: ;
            endcase
            // local fields go to every selected channel
            for (int i = 0; i < 2; i++) begin
                if (s_q.chsel[i]) begin
                    unique case (reg_addr)
                        afc_pkg::ADDR_POWER: s_d.c_sh[i].pwr = reg_wdata[1:0];
                        afc_pkg::ADDR_TEST: begin
                            s_d.c_sh[i].tst = reg_wdata[2:0];
                            s_d.c_sh[i].rst_long = reg_wdata[afc_pkg::TEST_RST_LONG_BIT];
                            s_d.c_sh[i].rst_short = reg_wdata[afc_pkg::TEST_RST_SHORT_BIT];
                        end
                        afc_pkg::ADDR_OFFSET: s_d.c_sh[i].ofs = reg_wdata[5:0];
                        afc_pkg::ADDR_OUTPUT: begin
                            s_d.c_sh[i].oe_n = reg_wdata[afc_pkg::OUT_OEN_BIT];
                            s_d.c_sh[i].inv = reg_wdata[afc_pkg::OUT_INV_BIT];
                            s_d.c_sh[i].fmt = reg_wdata[1:0];
                        end
                        default: ;
                    endcase
                end
            end
        end

        // register reads, channel A wins when both are selected
        ch = s_q.chsel[0] ? 1'b0 : 1'b1;
        rc = s_q.c_sh[ch];
        if (reg_rd) begin
            unique case (reg_addr)
                afc_pkg::ADDR_CHAN_INDEX: s_d.rdata = {6'h00, s_q.chsel};
                afc_pkg::ADDR_POWER: s_d.rdata = {2'h0, s_q.g_sh.pin_stby, 3'h0, rc.pwr};
                afc_pkg::ADDR_CLOCK: s_d.rdata = {7'h00, s_q.g_sh.dcs};
                afc_pkg::ADDR_DIVIDE: s_d.rdata = {5'h00, s_q.g_sh.div};
                afc_pkg::ADDR_TEST: s_d.rdata = {2'h0, rc.rst_long, rc.rst_short, 1'b0, rc.tst};
                afc_pkg::ADDR_OFFSET: s_d.rdata = {2'h0, rc.ofs};
                afc_pkg::ADDR_OUTPUT: s_d.rdata = {s_q.g_sh.drive, s_q.g_sh.lvds,
                    s_q.g_sh.ilv, rc.oe_n, 1'b0, rc.inv, rc.fmt};
                afc_pkg::ADDR_COMMIT: s_d.rdata = {7'h00, s_q.commit};
                default: s_d.rdata = 8'h00;
            endcase
        end

        // global output controls
        s_d.dcs_on = s_q.g_act.dcs | (s_q.g_act.div != 3'h0);
        s_d.lvds = s_q.g_act.lvds;
        s_d.drive = s_q.g_act.drive;
        s_d.dvalid = tick;

        // per-channel power, generators and data words
        for (int i = 0; i < 2; i++) begin
            s_d.pd[i] = (s_q.c_act[i].pwr == afc_pkg::PWR_OFF)
                | (pin & !s_q.g_act.pin_stby);
            s_d.sb[i] = (s_q.c_act[i].pwr == afc_pkg::PWR_STANDBY)
                | (pin & s_q.g_act.pin_stby);
            normal = !s_d.pd[i] && !s_d.sb[i];
            if (s_q.c_act[i].rst_long) begin
                s_d.lfsr_l[i] = afc_pkg::LONG_SEED;
            end else if (tick && normal && s_q.c_act[i].tst == afc_pkg::TST_LONG) begin
                s_d.lfsr_l[i] = {s_q.lfsr_l[i][21:0], s_q.lfsr_l[i][22] ^ s_q.lfsr_l[i][17]};
            end
            if (s_q.c_act[i].rst_short) begin
                s_d.lfsr_s[i] = afc_pkg::SHORT_SEED;
            end else if (tick && normal && s_q.c_act[i].tst == afc_pkg::TST_SHORT) begin
                s_d.lfsr_s[i] = {s_q.lfsr_s[i][7:0], s_q.lfsr_s[i][8] ^ s_q.lfsr_s[i][4]};
            end
            if (tick && normal) begin
                s_d.alt[i] = !s_q.alt[i];
            end
            word[i] = format_word(pick_word(s_q.c_act[i], adc_data[i], s_q.alt[i],
                s_q.lfsr_l[i], s_q.lfsr_s[i]), s_q.c_act[i].fmt, s_q.c_act[i].inv);
            s_d.doe[i] = !s_q.c_act[i].oe_n;
        end

        // place words on the buses, holding them outside normal operation
        if (s_q.g_act.ilv && !s_q.g_act.lvds) begin
            s_d.doe[1] = 1'b0;
            if (tick) begin
                s_d.ilv_sel = !s_q.ilv_sel;
                s_d.dchan = s_q.ilv_sel;
                if (!s_d.pd[s_q.ilv_sel] && !s_d.sb[s_q.ilv_sel]) begin
                    s_d.dout[0] = word[s_q.ilv_sel];
                end
            end
        end else if (tick) begin
            s_d.dchan = 1'b0;
            for (int i = 0; i < 2; i++) begin
                if (!s_d.pd[i] && !s_d.sb[i]) begin
                    s_d.dout[i] = word[i];
                end
            end
        end
    end

    // register state, constants only under reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.g_sh.dcs <= afc_pkg::DCS_RESET;
            s_q.g_act.dcs <= afc_pkg::DCS_RESET;
            s_q.dcs_on <= afc_pkg::DCS_RESET;
            s_q.chsel <= afc_pkg::CHAN_INDEX_RESET;
            s_q.lfsr_l <= {2{afc_pkg::LONG_SEED}};
            s_q.lfsr_s <= {2{afc_pkg::SHORT_SEED}};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state
    assign reg_rdata = s_q.rdata;
    assign data_out = s_q.dout;
    assign data_oe = s_q.doe;
    assign data_valid = s_q.dvalid;
    assign data_chan = s_q.dchan;
    assign chan_pd = s_q.pd;
    assign chan_sb = s_q.sb;
    assign dcs_on = s_q.dcs_on;
    assign bus_lvds = s_q.lvds;
    assign drive_low = s_q.drive;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    commit_self_clear_a: assert property (s_q.commit |=> !s_q.commit)
        else $error("commit bit did not clear");
    commit_copy_a: assert property (s_q.commit |=> (s_q.g_act == $past(s_q.g_sh))
        && (s_q.c_act == $past(s_q.c_sh)))
        else $error("commit did not copy shadow set");
    commit_write_a: assert property ((reg_wr && reg_addr == afc_pkg::ADDR_COMMIT
        && reg_wdata[0]) |=> s_q.commit ##1 !s_q.commit)
        else $error("commit write not seen");
    dcs_forced_a: assert property ((s_q.g_act.div != 3'h0) |=> dcs_on)
        else $error("stabilizer not forced by divider");
    standby_mode_a: assert property ((s_q.c_act[0].pwr == afc_pkg::PWR_STANDBY && !s_q.pin_s2)
        |=> chan_sb[0] && !chan_pd[0])
        else $error("standby code not applied");
    pin_shutdown_a: assert property ((s_q.pin_s2 && !s_q.g_act.pin_stby) |=> &chan_pd)
        else $error("shutdown pin did not power down");
    oe_off_a: assert property (s_q.c_act[0].oe_n |=> !data_oe[0])
        else $error("driver enabled while disabled");
    long_reset_a: assert property (s_q.c_act[1].rst_long [*2]
        |-> s_q.lfsr_l[1] == afc_pkg::LONG_SEED)
        else $error("long generator not held in reset");
    read_chan_a_a: assert property ((reg_rd && reg_addr == afc_pkg::ADDR_OFFSET
        && s_q.chsel == 2'h3) |=> reg_rdata == {2'h0, $past(s_q.c_sh[0].ofs)})
        else $error("dual select read not channel A");
    unused_zero_a: assert property ((reg_rd && reg_addr == afc_pkg::ADDR_COMMIT)
        |=> reg_rdata[7:1] == 7'h00)
        else $error("unused bits read nonzero");
    midscale_out_a: assert property ((tick && s_q.c_act[0].tst == afc_pkg::TST_MID
        && s_q.c_act[0].fmt == 2'h0 && !s_q.c_act[0].inv && !s_q.g_act.ilv
        && s_q.c_act[0].pwr == afc_pkg::PWR_NORMAL && !s_q.pin_s2)
        |=> data_out[0] == afc_pkg::MIDSCALE_CODE)
        else $error("midscale pattern missing");

    commit_seen_c: cover property (s_q.commit ##1 s_q.c_act[0].tst == afc_pkg::TST_LONG);
    ilv_seen_c: cover property (tick && s_q.g_act.ilv && !s_q.g_act.lvds);
    short_run_c: cover property (tick && s_q.c_act[1].tst == afc_pkg::TST_SHORT);
endmodule

// File: sim/afc_rx_model.sv
// downstream logic receiver for the converter output words
// assumes data_valid is a one-cycle pulse on clk per output word
`timescale 1ns/1ps
module afc_rx_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic data_valid,
    output logic [7:0] gap
);
    logic [7:0] cnt_q;

    // measure clocks between successive word pulses
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
            gap <= 8'h00;
        end else if (data_valid) begin
            gap <= cnt_q + 8'h01;
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// File: sim/afc_regs_tb.sv
// self-checking bench for the function configuration register bank
// assumes the byte register port and a 50 MHz clock
`timescale 1ns/1ps
module afc_regs_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic pdwn_pin = 1'b0;
    logic [1:0][13:0] adc_data = '0;
    logic [7:0] reg_rdata;
    logic [1:0][13:0] data_out;
    logic [1:0] data_oe;
    logic [1:0] chan_pd;
    logic [1:0] chan_sb;
    logic data_valid;
    logic data_chan;
    logic dcs_on;
    logic bus_lvds;
    logic drive_low;
    logic [7:0] gap;
    int errors = 0;
    int cmp_count = 0;
    logic [7:0] rv;
    logic [13:0] w0;
    logic [13:0] lo;
    logic c0;
    logic [15:0] rst_t [9] = '{16'h0503, 16'h0800, 16'h0901, 16'h0b00, 16'h0d00,
        16'h1000, 16'h1400, 16'hff00, 16'h0100};
    logic [23:0] rw_t [8] = '{24'h05ff03, 24'h082121, 24'h09fe00, 24'h0bff07,
        24'h0dff37, 24'h10ff3f, 24'h14fff7, 24'h0cff00};
    logic [47:0] fm_t [9] = '{48'h0000_1000_1000, 48'h0100_1000_3000,
        48'h0200_1000_1800, 48'h0300_1000_1000, 48'h0400_1000_2fff,
        48'h001f_1000_101f, 48'h0020_1000_0fe0, 48'h001f_3ff0_3fff,
        48'h003f_0000_0000};
    logic [15:0] pt_t [3] = '{16'h2000, 16'h3fff, 16'h0000};

    // 50 MHz clock
    always #10 clk = ~clk;

    afc_regs dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pdwn_pin(pdwn_pin), .adc_data(adc_data), .data_out(data_out),
        .data_oe(data_oe), .data_valid(data_valid), .data_chan(data_chan),
        .chan_pd(chan_pd), .chan_sb(chan_sb), .dcs_on(dcs_on),
        .bus_lvds(bus_lvds), .drive_low(drive_low));

    afc_rx_model rx (.clk(clk), .nrst(nrst), .data_valid(data_valid), .gap(gap));

    // byte write, one idle cycle after
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    // byte read, data one cycle after the strobe
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic commit();
        wr(afc_pkg::ADDR_COMMIT, 8'h01);
        settle(6);
    endtask

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkrd(input logic [8:0] a, input logic [7:0] e);
        rd(a, rv);
        check("reg_rdata", 16'(e), 16'(rv));
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        check("dcs_on", 16'h1, 16'(dcs_on));
        foreach (rst_t[i]) chkrd(9'(rst_t[i][15:8]), rst_t[i][7:0]);
        foreach (rw_t[i]) begin
            wr(9'(rw_t[i][23:16]), rw_t[i][15:8]);
            chkrd(9'(rw_t[i][23:16]), rw_t[i][7:0]);
        end
        check("bus_lvds", 16'h0, 16'(bus_lvds));
        // clear every register, channel index kept at both channels
        foreach (rw_t[i]) wr(9'(rw_t[i][23:16]), (i == 0) ? 8'h03 : 8'h00);
        wr(afc_pkg::ADDR_CHAN_INDEX, 8'h03);
        wr(afc_pkg::ADDR_CLOCK, 8'h01);
        // shadowed output settings take effect only on commit
        wr(afc_pkg::ADDR_OUTPUT, 8'hc0);
        settle(4);
        check("bus_lvds", 16'h0, 16'(bus_lvds));
        commit();
        check("bus_lvds", 16'h1, 16'(bus_lvds));
        check("drive_low", 16'h1, 16'(drive_low));
        chkrd(afc_pkg::ADDR_COMMIT, 8'h00);
        wr(afc_pkg::ADDR_OUTPUT, 8'h00);
        commit();
        check("drive_low", 16'h0, 16'(drive_low));
        // power modes, internal and from the pin
        for (int m = 1; m < 4; m++) begin
            wr(afc_pkg::ADDR_POWER, 8'(m));
            commit();
            check("chan_pd", (m == 1) ? 16'h3 : 16'h0, 16'(chan_pd));
            check("chan_sb", (m == 2) ? 16'h3 : 16'h0, 16'(chan_sb));
        end
        wr(afc_pkg::ADDR_POWER, 8'h00);
        commit();
        pdwn_pin <= 1'b1;
        settle(6);
        check("chan_pd", 16'h3, 16'(chan_pd));
        wr(afc_pkg::ADDR_POWER, 8'h20);
        commit();
        check("chan_sb", 16'h3, 16'(chan_sb));
        check("chan_pd", 16'h0, 16'(chan_pd));
        pdwn_pin <= 1'b0;
        wr(afc_pkg::ADDR_POWER, 8'h00);
        // divider and stabilizer
        wr(afc_pkg::ADDR_CLOCK, 8'h00);
        wr(afc_pkg::ADDR_DIVIDE, 8'h07);
        commit();
        settle(20);
        check("dcs_on", 16'h1, 16'(dcs_on));
        check("gap", 16'h8, 16'(gap));
        wr(afc_pkg::ADDR_DIVIDE, 8'h01);
        commit();
        check("gap", 16'h2, 16'(gap));
        check("dcs_on", 16'h1, 16'(dcs_on));
        wr(afc_pkg::ADDR_DIVIDE, 8'h00);
        commit();
        check("dcs_on", 16'h0, 16'(dcs_on));
        check("gap", 16'h1, 16'(gap));
        wr(afc_pkg::ADDR_CLOCK, 8'h01);
        // offset, format and invert on live samples
        foreach (fm_t[i]) begin
            wr(afc_pkg::ADDR_OFFSET, fm_t[i][39:32]);
            wr(afc_pkg::ADDR_OUTPUT, fm_t[i][47:40]);
            adc_data <= {fm_t[i][29:16], fm_t[i][29:16]};
            commit();
            check("data_out_a", fm_t[i][15:0], 16'(data_out[0]));
            check("data_out_b", fm_t[i][15:0], 16'(data_out[1]));
            check("data_oe", 16'h3, 16'(data_oe));
        end
        // fixed test words
        foreach (pt_t[i]) begin
            wr(afc_pkg::ADDR_TEST, 8'(i + 1));
            commit();
            check("pattern_a", pt_t[i], 16'(data_out[0]));
            check("pattern_b", pt_t[i], 16'(data_out[1]));
        end
        // alternating patterns flip every sample
        for (int k = 0; k < 2; k++) begin
            wr(afc_pkg::ADDR_TEST, k ? 8'h07 : 8'h04);
            lo = k ? 14'h0000 : 14'h1555;
            commit();
            w0 = data_out[0];
            check("alt_set", 16'h1, 16'((w0 === lo) || (w0 === (lo ^ 14'h3fff))));
            settle(1);
            check("alt_flip", 16'h3fff, 16'(w0 ^ data_out[0]));
        end
        // pseudorandom generators held at seed, then running
        for (int k = 0; k < 2; k++) begin
            wr(afc_pkg::ADDR_TEST, k ? 8'h16 : 8'h25);
            commit();
            check("seed", 16'h3fff, 16'(data_out[0]));
            settle(1);
            check("seed_hold", 16'h3fff, 16'(data_out[0]));
            wr(afc_pkg::ADDR_TEST, k ? 8'h06 : 8'h05);
            commit();
            w0 = data_out[0];
            settle(1);
            check("advance", 16'h1, 16'(w0 !== data_out[0]));
        end
        // per-channel access through the channel index
        wr(afc_pkg::ADDR_CHAN_INDEX, 8'h01);
        wr(afc_pkg::ADDR_TEST, 8'h01);
        wr(afc_pkg::ADDR_OUTPUT, 8'h10);
        wr(afc_pkg::ADDR_CHAN_INDEX, 8'h02);
        wr(afc_pkg::ADDR_TEST, 8'h02);
        chkrd(afc_pkg::ADDR_TEST, 8'h02);
        wr(afc_pkg::ADDR_CHAN_INDEX, 8'h03);
        chkrd(afc_pkg::ADDR_TEST, 8'h01);
        commit();
        check("data_oe", 16'h2, 16'(data_oe));
        check("chan_b", 16'h3fff, 16'(data_out[1]));
        // interleaved bus carries A then B
        wr(afc_pkg::ADDR_OUTPUT, 8'h20);
        commit();
        check("data_oe", 16'h1, 16'(data_oe));
        c0 = data_chan;
        for (int i = 0; i < 2; i++) begin
            settle(1);
            check("data_chan", 16'(!c0), 16'(data_chan));
            check("ilv_word", data_chan ? 16'h3fff : 16'h2000, 16'(data_out[0]));
            c0 = data_chan;
        end
        conclude();
    end
endmodule
